// ---- bench/oles_drive_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module oles_drive_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control from the bench
  input wire logic serve,
  input wire logic [7:0] gap,
  // toward the card
  output logic powerup_done,
  output logic frame_processed
);
  logic [7:0] cnt = 8'h00;
  initial powerup_done = 1'b0;
  initial frame_processed = 1'b0;
  // a silent drive (serve low) neither finishes power-up nor sends frames
  always @(negedge clk_sys)
  begin
    powerup_done <= rst_n && serve;
    if (!rst_n || !serve || cnt >= gap)
      cnt <= 8'h00;
    else
      cnt <= cnt + 8'h01;
    frame_processed <= rst_n && serve && cnt >= gap;
  end
endmodule // oles_drive_model
`default_nettype wire

// ---- bench/option_link_error_supervisor_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module option_link_error_supervisor_tb;
  import oles_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  oles_bus_state_type bus_state = OLES_BUS_INIT;
  logic watchdog_enable = 1'b0;
  logic watchdog_expired = 1'b0;
  logic drive_op_enabled = 1'b0;
  logic ident_checked = 1'b0;
  logic ident_match = 1'b0;
  logic [3:0] errs = 4'h0;
  logic serve = 1'b1;
  logic [7:0] gap = 8'h05;
  logic force_safeop, force_init, outbound_channel_disable;
  logic inbound_channel_disable, bus_fault, fault_valid, powerup_done;
  logic frame_processed, nonvolatile_store_write, error_indicator_lamp;
  logic [7:0] fault_code;
  logic [1:0] nonvolatile_store_cause;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 14;
  int i;
  int n;
  always #10 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  // short counts: one ms tick is 10 cycles
  oles_supervisor #(.TICK_COUNT(10), .POWERUP_LIMIT(5), .IDLE_LIMIT(4))
  i_oles_supervisor
  (
    .clk_sys, .rst_n, .bus_state, .watchdog_enable, .watchdog_expired,
    .force_safeop, .force_init, .outbound_channel_disable,
    .inbound_channel_disable, .drive_op_enabled, .frame_processed,
    .powerup_done, .ident_checked, .ident_match,
    .drive_sumcheck_err(errs[0]), .drive_ident_err(errs[1]),
    .card_sumcheck_err(errs[2]), .card_ident_err(errs[3]),
    .bus_fault, .fault_valid, .fault_code, .nonvolatile_store_write,
    .nonvolatile_store_cause, .error_indicator_lamp
  );
  oles_drive_model i_oles_drive_model
  (
    .clk_sys, .rst_n, .serve, .gap, .powerup_done, .frame_processed
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(negedge clk_sys);
  endtask
  function automatic logic [7:0] exp_code(int k);
    return k[0] ? FAULT_IDENT : FAULT_SUMCHECK;
  endfunction
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    tick(6);
    rst_n = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    chk("code_rst", FAULT_NONE, fault_code);
    for (i = 0; i < 4; i++)
    begin
      errs = 4'h1 << i;
      tick(1);
      errs = 4'h0;
      chk("fault_code", exp_code(i), fault_code);
      chk("fault_valid", 8'h01, 8'(fault_valid));
      chk("safeop", 8'h01, 8'(force_safeop));
      chk("out_dis", 8'(i < 2), 8'(outbound_channel_disable));
      chk("in_dis", 8'(i >= 2), 8'(inbound_channel_disable));
      bus_state = OLES_BUS_PREOP;
      tick(1);
      chk("dis_clr", 8'h00, 8'(outbound_channel_disable));
      bus_state = OLES_BUS_INIT;
      tick(1);
    end
    // drops from op raise the fault line only while the drive is enabled
    for (i = 0; i < 4; i++)
    begin
      drive_op_enabled = i[1];
      bus_state = OLES_BUS_OP;
      tick(2);
      bus_state = i[0] ? OLES_BUS_PREOP : OLES_BUS_SAFEOP;
      tick(4);
      chk("bus_fault", 8'(i[1]), 8'(bus_fault));
      bus_state = OLES_BUS_OP;
      tick(1);
      chk("bus_clr", 8'h00, 8'(bus_fault));
    end
    drive_op_enabled = 1'b0;
    for (i = 0; i < 2; i++)
    begin
      watchdog_enable = i[0];
      watchdog_expired = 1'b1;
      tick(1);
      watchdog_expired = 1'b0;
      tick(2);
      chk("wd_fault", 8'(i[0]), 8'(bus_fault));
      bus_state = OLES_BUS_INIT;
      tick(1);
      bus_state = OLES_BUS_OP;
      tick(1);
    end
    watchdog_enable = 1'b0;
    n = 0;
    for (i = 0; i < 600; i++)
    begin
      if (i % 20 == 0)
        gap = 8'(1 + {$random(seed)} % 30);
      tick(1);
      if (force_init !== 1'b0 || nonvolatile_store_write !== 1'b0)
        n++;
    end
    chk("idle_ok", 8'h00, 8'(n));
    ident_checked = 1'b1;
    tick(1);
    ident_checked = 1'b0;
    chk("id_wr", 8'h01, 8'(nonvolatile_store_write));
    chk("id_cause", 8'(CAUSE_IDENT), 8'(nonvolatile_store_cause));
    chk("id_lamp", 8'h01, 8'(error_indicator_lamp));
    // a second identity report is ignored
    ident_checked = 1'b1;
    tick(1);
    ident_checked = 1'b0;
    chk("id_again", 8'h00, 8'(nonvolatile_store_write));
    serve = 1'b0;
    n = 0;
    while (force_init !== 1'b1 && n < 120)
    begin
      tick(1);
      n++;
    end
    chk("to_init", 8'h01, 8'(force_init));
    chk("to_wr", 8'h01, 8'(nonvolatile_store_write));
    chk("to_cause", 8'(CAUSE_IFTIMEOUT), 8'(nonvolatile_store_cause));
    chk("to_late", 8'h01, 8'(n > 25));
    do_reset();
    n = 0;
    while (fault_valid !== 1'b1 && n < 120)
    begin
      tick(1);
      n++;
    end
    chk("pu_code", FAULT_POWERUP, fault_code);
    chk("pu_wr", 8'h01, 8'(nonvolatile_store_write));
    chk("pu_cause", 8'(CAUSE_POWERUP), 8'(nonvolatile_store_cause));
    chk("pu_late", 8'h01, 8'(n > 35));
    print_verdict();
  end
  initial
  begin
    #(20 * 4000);
    mismatches++;
    print_verdict();
  end
endmodule // option_link_error_supervisor_tb
`default_nettype wire

// ---- hdl/oles_pkg.sv ----
package oles_pkg;
  // fieldbus states
  typedef enum logic [3:0]
  {
    OLES_BUS_INIT = 4'h1,
    OLES_BUS_PREOP = 4'h2,
    OLES_BUS_SAFEOP = 4'h4,
    OLES_BUS_OP = 4'h8
  } oles_bus_state_type;

  // drive fault codes, low byte of OFxNN
  localparam logic [7:0] FAULT_NONE = 8'hFF;
  localparam logic [7:0] FAULT_POWERUP = 8'h00;
  localparam logic [7:0] FAULT_IDENT = 8'h30;
  localparam logic [7:0] FAULT_SUMCHECK = 8'h32;

  // fatal record causes
  localparam logic [1:0] CAUSE_POWERUP = 2'h0;
  localparam logic [1:0] CAUSE_IFTIMEOUT = 2'h1;
  localparam logic [1:0] CAUSE_IDENT = 2'h2;

  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int POWERUP_S = 10;
  localparam int POWERUP_MS = POWERUP_S * 1000;
  localparam int IF_TIMEOUT_MS = 1000;
endpackage

// ---- hdl/oles_supervisor.sv ----
// Operation
// - op to safeop/preop while drive enabled raises a bus fault
// - bus fault holds until next lower-to-higher fieldbus transition
// - enabled watchdog expiring without output refresh raises bus fault
// - drive-detected sum-check gives OFx32, identity error gives OFx30
// - drive-detected error disables outbound channel, forces safe-op
// - card-detected sum-check gives OFx32, identity error gives OFx30
// - card-detected error disables inbound channel, forces safe-op
// - power-up handshake unfinished after 10 s is fatal, fault OFx00
// - each fatal error logs a nonvolatile record, lamp steady red
// - no drive frame processed for 1000 ms is a fatal timeout
// - interface timeout forces fieldbus back to init
// - identification string mismatch at power-up is a fatal error
`timescale 1ns/1ns
`default_nettype none
module oles_supervisor
#(
  parameter int TICK_COUNT = oles_pkg::TICK_CYCLES,
  parameter int POWERUP_LIMIT = oles_pkg::POWERUP_MS,
  parameter int IDLE_LIMIT = oles_pkg::IF_TIMEOUT_MS
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // fieldbus side
  input wire oles_pkg::oles_bus_state_type bus_state,
  input wire logic watchdog_enable,
  input wire logic watchdog_expired,
  output logic force_safeop,
  output logic force_init,
  output logic outbound_channel_disable,
  output logic inbound_channel_disable,
  // drive side
  input wire logic drive_op_enabled,
  input wire logic frame_processed,
  input wire logic powerup_done,
  input wire logic ident_checked,
  input wire logic ident_match,
  input wire logic drive_sumcheck_err,
  input wire logic drive_ident_err,
  input wire logic card_sumcheck_err,
  input wire logic card_ident_err,
  output logic bus_fault,
  output logic fault_valid,
  output logic [7:0] fault_code,
  // nonvolatile store and lamp
  output logic nonvolatile_store_write,
  output logic [1:0] nonvolatile_store_cause,
  output logic error_indicator_lamp
);
  import oles_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [1:0] bus_rank(input oles_bus_state_type s);
    case (s)
      OLES_BUS_PREOP: bus_rank = 2'h1;
      OLES_BUS_SAFEOP: bus_rank = 2'h2;
      OLES_BUS_OP: bus_rank = 2'h3;
      default: bus_rank = 2'h0;
    endcase
  endfunction

  oles_bus_state_type last_state;
  logic [25:0] tick_cnt;
  logic ms_tick;
  logic [13:0] powerup_ms;
  logic [13:0] idle_ms;
  logic powerup_pending;
  logic ident_seen;
  logic fatal_latched;
  logic op_drop;
  logic step_up;
  logic powerup_fatal;
  logic idle_fatal;
  logic ident_fatal;
  logic drive_err;
  logic card_err;

  assign op_drop = last_state == OLES_BUS_OP &&
    (bus_state == OLES_BUS_SAFEOP || bus_state == OLES_BUS_PREOP);
  assign step_up = bus_rank(bus_state) > bus_rank(last_state);
  assign drive_err = drive_sumcheck_err | drive_ident_err;
  assign card_err = card_sumcheck_err | card_ident_err;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      last_state <= OLES_BUS_INIT;
    else
      last_state <= bus_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond time base
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || ms_tick)
      tick_cnt <= 26'h0000000;
    else
      tick_cnt <= tick_cnt + 26'h0000001;
  end
  assign ms_tick = tick_cnt == 26'(TICK_COUNT - 1);

  ////////////////////////////////////////////////////////////////////////////
  // bus fault toward the drive
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      bus_fault <= 1'b0;
    else if (op_drop && drive_op_enabled)
      bus_fault <= 1'b1;
    else if (watchdog_enable && watchdog_expired)
      bus_fault <= 1'b1;
    else if (step_up)
      bus_fault <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sum-check and identity faults
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      outbound_channel_disable <= 1'b0;
      inbound_channel_disable <= 1'b0;
    end
    else
    begin
      if (drive_err)
        outbound_channel_disable <= 1'b1;
      else if (step_up)
        outbound_channel_disable <= 1'b0;
      if (card_err)
        inbound_channel_disable <= 1'b1;
      else if (step_up)
        inbound_channel_disable <= 1'b0;
    end
  end

  // safe-op is forced in the same cycle as the channel is disabled
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      force_safeop <= 1'b0;
    else
      force_safeop <= drive_err | card_err;
  end

  // fault report; power-up fault wins, then sum-check, then identity
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      fault_valid <= 1'b0;
      fault_code <= FAULT_NONE;
    end
    else
    begin
      fault_valid <= powerup_fatal | drive_err | card_err;
      if (powerup_fatal)
        fault_code <= FAULT_POWERUP;
      else if (drive_sumcheck_err || card_sumcheck_err)
        fault_code <= FAULT_SUMCHECK;
      else if (drive_ident_err || card_ident_err)
        fault_code <= FAULT_IDENT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-up supervision; relies on the drive finishing its handshake
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      powerup_pending <= 1'b1;
      powerup_ms <= 14'h0000;
    end
    else if (powerup_done || powerup_fatal)
      powerup_pending <= 1'b0;
    else if (powerup_pending && ms_tick)
      powerup_ms <= powerup_ms + 14'h0001;
  end
  assign powerup_fatal = powerup_pending && !powerup_done &&
    powerup_ms >= 14'(POWERUP_LIMIT);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      ident_seen <= 1'b0;
    else if (ident_checked)
      ident_seen <= 1'b1;
  end
  assign ident_fatal = ident_checked && !ident_seen && !ident_match;

  ////////////////////////////////////////////////////////////////////////////
  // interface inactivity; armed once power-up has finished
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || frame_processed || powerup_pending)
      idle_ms <= 14'h0000;
    else if (ms_tick && !idle_fatal && idle_ms < 14'(IDLE_LIMIT))
      idle_ms <= idle_ms + 14'h0001;
  end
  assign idle_fatal = idle_ms == 14'(IDLE_LIMIT) && ms_tick &&
    !frame_processed;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      force_init <= 1'b0;
    else
      force_init <= idle_fatal;
  end

  ////////////////////////////////////////////////////////////////////////////
  // fatal record and lamp; lamp stays red until rst_n is asserted
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      nonvolatile_store_write <= 1'b0;
      nonvolatile_store_cause <= CAUSE_POWERUP;
      fatal_latched <= 1'b0;
    end
    else
    begin
      nonvolatile_store_write <= powerup_fatal | idle_fatal | ident_fatal;
      if (powerup_fatal)
        nonvolatile_store_cause <= CAUSE_POWERUP;
      else if (idle_fatal)
        nonvolatile_store_cause <= CAUSE_IFTIMEOUT;
      else if (ident_fatal)
        nonvolatile_store_cause <= CAUSE_IDENT;
      if (powerup_fatal || idle_fatal || ident_fatal)
        fatal_latched <= 1'b1;
    end
  end
  assign error_indicator_lamp = fatal_latched;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  op_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_drop && drive_op_enabled |=> bus_fault)
    else $error("bus fault missing after op drop");
  fault_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_fault && !step_up |=> bus_fault)
    else $error("bus fault cleared without state step up");
  wd_fault_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    watchdog_enable && watchdog_expired |=> bus_fault)
    else $error("watchdog expiry not reported");
  sum_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    drive_sumcheck_err && !powerup_fatal |=>
      fault_valid && fault_code == FAULT_SUMCHECK)
    else $error("sum-check fault code wrong");
  out_chan_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    drive_err |=> outbound_channel_disable && force_safeop)
    else $error("outbound channel not disabled");
  card_ident_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    card_ident_err && !card_sumcheck_err && !drive_sumcheck_err &&
      !powerup_fatal |=> fault_code == FAULT_IDENT)
    else $error("identity fault code wrong");
  in_chan_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    card_err |=> inbound_channel_disable && force_safeop)
    else $error("inbound channel not disabled");
  powerup_late_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    powerup_fatal |=> fault_code == FAULT_POWERUP && nonvolatile_store_write)
    else $error("power-up timeout not reported");
  lamp_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    error_indicator_lamp |=> error_indicator_lamp)
    else $error("lamp dropped after fatal error");
  idle_init_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    idle_fatal |=> force_init && error_indicator_lamp &&
      nonvolatile_store_cause == CAUSE_IFTIMEOUT)
    else $error("timeout did not force init");
  ident_bad_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ident_fatal && !powerup_fatal && !idle_fatal |=>
      nonvolatile_store_cause == CAUSE_IDENT)
    else $error("identity mismatch not logged");
  idle_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_processed |=> idle_ms == 14'h0000)
    else $error("idle timer not restarted");
  // a step up with no new cause in the same cycle must clear the fault
  step_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_fault && step_up && !(op_drop && drive_op_enabled) &&
      !(watchdog_enable && watchdog_expired) |=> !bus_fault)
    else $error("bus fault not cleared on state step up");
  drive_ident_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    drive_ident_err && !drive_sumcheck_err && !card_sumcheck_err &&
      !powerup_fatal |=> fault_valid && fault_code == FAULT_IDENT)
    else $error("drive identity fault code wrong");
  fatal_log_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    powerup_fatal || idle_fatal || ident_fatal |=>
      nonvolatile_store_write && error_indicator_lamp)
    else $error("fatal error not logged");
  idle_fatal_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    idle_fatal |=> nonvolatile_store_write && force_init)
    else $error("interface timeout not fatal");
  pu_once_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    powerup_fatal |=> !powerup_pending)
    else $error("power-up supervision not stopped");
  tick_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ms_tick |=> tick_cnt == 26'h0000000)
    else $error("ms time base did not wrap");
endmodule // oles_supervisor
`default_nettype wire
